// *** src/spb_pkg.sv ***
// Shared constants, types and register layout for the serial readback register bank
package spb_pkg;

  // ----------------------------------------------------------------
  // Serial frame geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_LEN = 5'h18;  // Bits in one access cycle
  localparam logic [4:0] FRAME_MSB = 5'h17;  // First bit shifted out
  localparam logic [4:0] CNT_STEP = 5'h01;

  // ----------------------------------------------------------------
  // Register offsets (7-bit address field)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_SOFT_RESET = 7'h00;
  localparam logic [6:0] OFS_PAGE_SELECT = 7'h01;
  localparam logic [6:0] OFS_GENERAL_STATUS = 7'h03;
  localparam logic [6:0] OFS_ALARM_LOW = 7'h04;
  localparam logic [6:0] OFS_ALARM_HIGH = 7'h05;
  localparam logic [6:0] OFS_SUPPLY_STATUS = 7'h06;
  localparam logic [6:0] OFS_OUTPUT_STATE = 7'h07;
  localparam logic [6:0] OFS_POWER_ENABLE = 7'h08;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SOFT_RESET = 16'h0000;
  localparam logic [15:0] RST_PAGE_SELECT = 16'h0000;
  localparam logic [15:0] RST_GENERAL_STATUS = 16'h4000;
  localparam logic [15:0] RST_ALARM_LOW = 16'h0000;
  localparam logic [15:0] RST_ALARM_HIGH = 16'h0000;
  localparam logic [15:0] RST_SUPPLY_STATUS = 16'h0001;
  localparam logic [15:0] RST_OUTPUT_STATE = 16'h0000;
  localparam logic [15:0] RST_POWER_ENABLE = 16'h0200;
  localparam logic [15:0] MASK_SOFT_RESET = 16'hFFFF;
  localparam logic [15:0] MASK_PAGE_SELECT = 16'h001F;
  localparam logic [15:0] MASK_POWER_ENABLE = 16'h02FF;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Status input slots, index 0 is the general status word
  localparam int unsigned STAT_SLOTS = 5;
  localparam logic [STAT_SLOTS-1:0][15:0] STAT_RST = {
    RST_OUTPUT_STATE, RST_SUPPLY_STATUS, RST_ALARM_HIGH, RST_ALARM_LOW, RST_GENERAL_STATUS};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned AMP_ON_BIT = 9;
  localparam int unsigned OUT_PWR_W = 8;
  localparam int unsigned STATUS_ECHO_W = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rw;          // 1 = read, 0 = write
    logic [6:0] addr;
    logic [15:0] data;
  } spb_cmd_t;

  typedef struct packed {
    logic rw_echo;
    logic [STATUS_ECHO_W-1:0] status;
    logic [15:0] data;
  } spb_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_BUILD
  } spb_state_t;

endpackage

// *** src/spb_regs.sv ***
// Global-page register storage with synchronised status inputs and registered read data
`timescale 1ns/100ps
`default_nettype none
module spb_regs #(
  parameter logic [15:0] SOFT_RESET_KEY = 16'h0001
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [6:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [spb_pkg::STAT_SLOTS-1:0][15:0] stat_in,
  output logic [15:0] rdata_q,
  output logic [15:0] general_status_q,
  output logic [15:0] page_q,
  output logic [15:0] pwr_q,
  output logic soft_rst_q
);

  // Address match, used by the write and soft reset decodes below
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [spb_pkg::STAT_SLOTS-1:0][15:0] meta_q;
  logic [spb_pkg::STAT_SLOTS-1:0][15:0] stat_q;
  logic [15:0] nop_q, nop_d, page_d, pwr_d, rdata_d;
  logic soft_rst_d, key_hit;

  // ----------------------------------------------------------------
  // Status synchronisers, two stages per word
  // ----------------------------------------------------------------
  // Words may tear across bits; status is slow so a tear lasts one cycle
  for (genvar i = 0; i < spb_pkg::STAT_SLOTS; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= spb_pkg::STAT_RST[i];
        stat_q[i] <= spb_pkg::STAT_RST[i];
      end else begin
        meta_q[i] <= stat_in[i];
        stat_q[i] <= meta_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write, soft reset and read decode
  // ----------------------------------------------------------------
  always_comb begin
    key_hit = wr_en && hit(addr, spb_pkg::OFS_SOFT_RESET) && (wdata == SOFT_RESET_KEY);
    nop_d = nop_q;
    page_d = page_q;
    pwr_d = pwr_q;
    if (wr_en && hit(addr, spb_pkg::OFS_SOFT_RESET)) begin
      nop_d = wdata & spb_pkg::MASK_SOFT_RESET;
    end
    if (wr_en && hit(addr, spb_pkg::OFS_PAGE_SELECT)) begin
      page_d = wdata & spb_pkg::MASK_PAGE_SELECT;
    end
    if (wr_en && hit(addr, spb_pkg::OFS_POWER_ENABLE)) begin
      pwr_d = wdata & spb_pkg::MASK_POWER_ENABLE;
    end
    // Soft reset returns control words to their defaults
    if (key_hit) begin
      page_d = spb_pkg::RST_PAGE_SELECT;
      pwr_d = spb_pkg::RST_POWER_ENABLE;
    end
    soft_rst_d = key_hit;
    case (addr)
      spb_pkg::OFS_SOFT_RESET: rdata_d = nop_q;
      spb_pkg::OFS_PAGE_SELECT: rdata_d = page_q;
      spb_pkg::OFS_GENERAL_STATUS: rdata_d = stat_q[0];
      spb_pkg::OFS_ALARM_LOW: rdata_d = stat_q[1];
      spb_pkg::OFS_ALARM_HIGH: rdata_d = stat_q[2];
      spb_pkg::OFS_SUPPLY_STATUS: rdata_d = stat_q[3];
      spb_pkg::OFS_OUTPUT_STATE: rdata_d = stat_q[4];
      spb_pkg::OFS_POWER_ENABLE: rdata_d = pwr_q;
      default: rdata_d = spb_pkg::READ_ZERO;  // Unmapped reads as zero
    endcase
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nop_q <= spb_pkg::RST_SOFT_RESET;
      page_q <= spb_pkg::RST_PAGE_SELECT;
      pwr_q <= spb_pkg::RST_POWER_ENABLE;
      rdata_q <= spb_pkg::READ_ZERO;
      soft_rst_q <= 1'b0;
    end else begin
      nop_q <= nop_d;
      page_q <= page_d;
      pwr_q <= pwr_d;
      rdata_q <= rdata_d;
      soft_rst_q <= soft_rst_d;
    end
  end

  assign general_status_q = stat_q[0];

endmodule // spb_regs
`default_nettype wire

// *** src/spb_spi_global_regs.sv ***
// Serial access port with 24-bit readback frame over the global-page registers
//
// Overview of operation
// - Readback frame bit 23 echoes the read/write flag of the previous cycle.
// - Frame bits 22 to 16 carry general status bits 6 to 0.
// - Frame bits 15 to 0 carry the register addressed by the previous command.
// - Power enable holds amplifier-on plus eight output enables, resets to 0200 hex.
// - Cycles are 24 bits; shorter ignored, longer keep only the last 24.
`timescale 1ns/100ps
`default_nettype none
module spb_spi_global_regs #(
  parameter logic [15:0] SOFT_RESET_KEY = 16'h0001  // Arbitrary key value
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic READBACK_OUTPUT_ENABLE,
  input wire logic [15:0] GENERAL_STATUS_IN,
  input wire logic [15:0] ALARM_LOW_IN,
  input wire logic [15:0] ALARM_HIGH_IN,
  input wire logic [15:0] SUPPLY_STATUS_IN,
  input wire logic [15:0] OUTPUT_STATE_IN,
  output logic [15:0] PAGE_SELECT,
  output logic [15:0] POWER_ENABLE,
  output logic SOFT_RESET_PULSE
);

  // ----------------------------------------------------------------
  // Link domain: shift in on SCLK falling edges
  // ----------------------------------------------------------------
  // Edge count and serial output are held clear while chip select is high; SCLK may stop
  // between frames so nothing here waits for an edge outside a frame.
  logic link_rst_n;
  logic [23:0] shift_q, shift_d;
  logic [4:0] icnt_q, icnt_d;
  logic full_q, full_d;
  logic tgl_q, tgl_d;

  assign link_rst_n = RST_N & ~CS_N;

  // Keep a rolling window of the last 24 bits
  always_comb begin
    shift_d = {shift_q[22:0], SDI};
    icnt_d = (icnt_q == spb_pkg::FRAME_LEN) ? icnt_q : icnt_q + spb_pkg::CNT_STEP;
    full_d = (icnt_d == spb_pkg::FRAME_LEN);
    // Flips once per frame that reaches 24 edges, so a bare chip select pulse
    // cannot make the core take the old window a second time
    tgl_d = (icnt_q == spb_pkg::FRAME_MSB) ? ~tgl_q : tgl_q;
  end

  // Shift window and length flag survive chip select so the core can read them
  always_ff @(negedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_q <= '0;
      full_q <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      full_q <= full_d;
      tgl_q <= tgl_d;
    end
  end

  // Edge count restarts with every frame
  always_ff @(negedge SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      icnt_q <= '0;
    end else begin
      icnt_q <= icnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: shift out on SCLK rising edges
  // ----------------------------------------------------------------
  spb_pkg::spb_frame_t frame_q, frame_d;
  logic rb_en_q, rb_en_d;
  logic [4:0] ocnt_q, ocnt_d;
  logic [4:0] oidx;
  logic sdo_d, oe_d;

  // Launch frame bit MSB first; drive low once the 24 bits are out
  always_comb begin
    oidx = spb_pkg::FRAME_MSB - ocnt_q;
    ocnt_d = (ocnt_q == spb_pkg::FRAME_LEN) ? ocnt_q : ocnt_q + spb_pkg::CNT_STEP;
    // Gated by the latched enable so an undriven pin never shows frame data
    sdo_d = (rb_en_q && ocnt_q < spb_pkg::FRAME_LEN) ? frame_q[oidx] : 1'b0;
    oe_d = rb_en_q;
  end

  // Released asynchronously by chip select so the pin floats between frames
  always_ff @(posedge SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ocnt_q <= '0;
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
    end else begin
      ocnt_q <= ocnt_d;
      SDO <= sdo_d;
      SDO_OE <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: chip select and readback enable synchronisers
  // ----------------------------------------------------------------
  logic cs_meta_q, cs_sync_q, cs_prev_q;
  logic en_meta_q, en_sync_q;
  logic frame_end;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= CS_N;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      en_meta_q <= READBACK_OUTPUT_ENABLE;
      en_sync_q <= en_meta_q;
    end
  end

  // Rising chip select marks the end of an access cycle
  assign frame_end = cs_sync_q & ~cs_prev_q;

  // ----------------------------------------------------------------
  // Core domain: command decode and readback frame build
  // ----------------------------------------------------------------
  // The shift window and length flag are only sampled after chip select
  // has risen and passed the synchroniser, when SCLK is quiet and both
  // words are stable; that qualification is the crossing.
  spb_pkg::spb_state_t state_q, state_d;
  spb_pkg::spb_cmd_t cmd_q, cmd_d;
  logic reg_wr;
  logic [15:0] rdata, general_status, page_word, pwr_word;
  logic soft_rst;
  // Frame toggle last taken; a frame without new edges is not taken again
  logic seen_q, seen_d;

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    frame_d = frame_q;
    rb_en_d = rb_en_q;
    seen_d = seen_q;
    reg_wr = 1'b0;
    case (state_q)
      spb_pkg::ST_IDLE: begin
        // Short cycles leave command and frame untouched
        if (frame_end && full_q && (tgl_q != seen_q)) begin
          cmd_d = spb_pkg::spb_cmd_t'(shift_q);
          seen_d = tgl_q;
          state_d = spb_pkg::ST_ACCESS;
        end
      end
      spb_pkg::ST_ACCESS: begin
        reg_wr = ~cmd_q.rw;
        state_d = spb_pkg::ST_BUILD;
      end
      spb_pkg::ST_BUILD: begin
        frame_d.rw_echo = cmd_q.rw;
        frame_d.status = general_status[spb_pkg::STATUS_ECHO_W-1:0];
        frame_d.data = rdata;
        rb_en_d = en_sync_q;
        state_d = spb_pkg::ST_IDLE;
      end
      default: begin
        state_d = spb_pkg::ST_IDLE;
      end
    endcase
  end

  // Frame and enable only change while chip select is high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= spb_pkg::ST_IDLE;
      cmd_q <= '0;
      frame_q <= '0;
      rb_en_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      frame_q <= frame_d;
      rb_en_q <= rb_en_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  spb_regs #(
    .SOFT_RESET_KEY(SOFT_RESET_KEY)
  ) u_regs (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_en(reg_wr),
    .addr(cmd_q.addr),
    .wdata(cmd_q.data),
    .stat_in({OUTPUT_STATE_IN, SUPPLY_STATUS_IN, ALARM_HIGH_IN, ALARM_LOW_IN,
              GENERAL_STATUS_IN}),
    .rdata_q(rdata),
    .general_status_q(general_status),
    .page_q(page_word),
    .pwr_q(pwr_word),
    .soft_rst_q(soft_rst)
  );

  // Control outputs come straight from the bank's flip-flops
  assign PAGE_SELECT = page_word;
  assign POWER_ENABLE = pwr_word;
  assign SOFT_RESET_PULSE = soft_rst;

endmodule // spb_spi_global_regs
`default_nettype wire

// *** bench/spb_spi_global_regs_props.sv ***
// Concurrent checks on the serial register bank ports
`timescale 1ns/100ps
`default_nettype none
module spb_chk #(
  parameter logic [15:0] SOFT_RESET_KEY = 16'h0001
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic READBACK_OUTPUT_ENABLE,
  input wire logic [15:0] GENERAL_STATUS_IN,
  input wire logic [15:0] ALARM_LOW_IN,
  input wire logic [15:0] ALARM_HIGH_IN,
  input wire logic [15:0] SUPPLY_STATUS_IN,
  input wire logic [15:0] OUTPUT_STATE_IN,
  input wire logic [15:0] PAGE_SELECT,
  input wire logic [15:0] POWER_ENABLE,
  input wire logic SOFT_RESET_PULSE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Register outputs
  // ----
  a_pwr_rsv_zero: assert property ((POWER_ENABLE & 16'hFD00) == 16'h0000)
    else $error("power enable reserved bits set");
  a_page_rsv_zero: assert property (PAGE_SELECT[15:5] == 11'h000)
    else $error("page select reserved bits set");
  // Writes land only after the frame has closed
  a_pwr_after_cs: assert property ($changed(POWER_ENABLE) |-> CS_N && $past(CS_N, 3))
    else $error("power enable changed inside a frame");
  a_page_after_cs: assert property ($changed(PAGE_SELECT) |-> $past(CS_N, 2))
    else $error("page select changed inside a frame");
  a_soft_restore: assert property ($rose(SOFT_RESET_PULSE) |-> ##[0:2]
    (POWER_ENABLE == 16'h0200 && PAGE_SELECT == 16'h0000))
    else $error("soft reset did not restore registers");
  a_pulse_single: assert property (SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
    else $error("soft reset pulse too long");
  // ----
  // Serial output side
  // ----
  a_sdo_gated: assert property (!SDO_OE |-> !SDO)
    else $error("data out high while not driven");
  a_oe_idle: assert property (CS_N |-> !SDO_OE)
    else $error("output enabled while deselected");
endmodule // spb_chk
bind spb_spi_global_regs spb_chk #(.SOFT_RESET_KEY(SOFT_RESET_KEY)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO),
  .SDO_OE(SDO_OE), .READBACK_OUTPUT_ENABLE(READBACK_OUTPUT_ENABLE),
  .GENERAL_STATUS_IN(GENERAL_STATUS_IN), .ALARM_LOW_IN(ALARM_LOW_IN),
  .ALARM_HIGH_IN(ALARM_HIGH_IN), .SUPPLY_STATUS_IN(SUPPLY_STATUS_IN),
  .OUTPUT_STATE_IN(OUTPUT_STATE_IN), .PAGE_SELECT(PAGE_SELECT),
  .POWER_ENABLE(POWER_ENABLE), .SOFT_RESET_PULSE(SOFT_RESET_PULSE));
`default_nettype wire

// *** bench/spb_host_model.sv ***
// Behavioural serial host that frames access cycles and collects readback
`timescale 1ns/100ps
`default_nettype none
module spb_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic ln;
  logic oe_seen;
  // Idle levels, clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    ln = 1'b0;
    oe_seen = 1'b0;
  end
  // One access cycle of n bits, half period 32 ns
  task automatic xfer(input int n, input logic [31:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    cs_n = 1'b0;
    #32;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = tx[i];
      #32;
      sclk = 1'b0;
      ln = sdo_oe ? sdo : ~ln;  // Released line shows no stale bit
      oe_seen = oe_seen | sdo_oe;
      rx = {rx[22:0], ln};
      #32;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    #200;  // Gap lets the core build the next frame
  endtask
  // Read command, then a harmless read cycle that collects the answer
  task automatic rd(input logic [6:0] a, output logic [23:0] r1, output logic [23:0] r2);
    xfer(24, {8'h00, 1'b1, a, 16'h0000}, r1);
    xfer(24, {8'h00, 1'b1, 7'h02, 16'h0000}, r2);
  endtask
endmodule // spb_host_model
`default_nettype wire

// *** bench/spb_spi_global_regs_tb.sv ***
// Self-checking bench for the serial register bank
`timescale 1ns/100ps
`default_nettype none
module spb_spi_global_regs_tb;
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } spb_row_t;
  localparam logic [15:0] KEY = 16'h0001;  // Arbitrary key value
  logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, rb_en, pulse, pulse_seen;
  logic [15:0] gs, al, ah, ss, os, page, pwr;
  logic [23:0] r1, r2;
  int errors, check_count;
  spb_row_t rows [10];
  spb_spi_global_regs #(.SOFT_RESET_KEY(KEY)) DUT (
    .CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
    .SDO_OE(sdo_oe), .READBACK_OUTPUT_ENABLE(rb_en), .GENERAL_STATUS_IN(gs),
    .ALARM_LOW_IN(al), .ALARM_HIGH_IN(ah), .SUPPLY_STATUS_IN(ss),
    .OUTPUT_STATE_IN(os), .PAGE_SELECT(page), .POWER_ENABLE(pwr),
    .SOFT_RESET_PULSE(pulse));
  spb_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  // Core clock, 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Catch the one-cycle pulse
  always @(posedge clk) begin
    if (pulse === 1'b1) pulse_seen <= 1'b1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, about four times the expected run
  initial begin
    #300000;
    errors++;
    conclude();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    rb_en = 1'b1;
    pulse_seen = 1'b0;
    gs = 16'hA5C3;
    al = 16'h1111;
    ah = 16'h2222;
    ss = 16'h3333;
    os = 16'h4444;
    errors = 0;
    check_count = 0;
    rows = '{'{7'h08, 16'hFFFF, 16'h02FF}, '{7'h01, 16'hFFFF, 16'h001F},
      '{7'h00, 16'h1234, 16'h1234}, '{7'h03, 16'hFFFF, 16'hA5C3},
      '{7'h04, 16'hFFFF, 16'h1111}, '{7'h05, 16'hFFFF, 16'h2222},
      '{7'h06, 16'hFFFF, 16'h3333}, '{7'h07, 16'hFFFF, 16'h4444},
      '{7'h02, 16'hFFFF, 16'h0000}, '{7'h7F, 16'hFFFF, 16'h0000}};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    // Write each place, then read it back; write echo shows in the read command frame
    foreach (rows[i]) begin
      host.xfer(24, {8'h00, 1'b0, rows[i].addr, rows[i].wdata}, r1);
      host.rd(rows[i].addr, r1, r2);
      chk(r1 & 24'h800000, 24'h000000);
      chk(r2, {1'b1, gs[6:0], rows[i].exp});
    end
    chk({pwr, page[7:0]}, {16'h02FF, 8'h1F});
    $display("register table done");
    // Short cycle is ignored, long cycle keeps the last 24 bits
    host.xfer(20, {8'h00, 1'b0, 7'h08, 16'h0000}, r1);
    chk({8'h00, pwr}, 24'h0002FF);
    host.xfer(28, {4'h0, 4'hA, 1'b0, 7'h08, 16'h0003}, r1);
    chk({8'h00, pwr}, 24'h000003);
    $display("frame length done");
    // No output drive while readback is off; the read command cycle still
    // carries the enable latched earlier, so only the collecting cycle is watched
    @(negedge clk);
    rb_en = 1'b0;
    host.xfer(24, {8'h00, 1'b1, 7'h08, 16'h0000}, r1);
    host.oe_seen = 1'b0;
    host.xfer(24, {8'h00, 1'b1, 7'h02, 16'h0000}, r2);
    chk({23'h000000, host.oe_seen}, 24'h000000);
    @(negedge clk);
    rb_en = 1'b1;
    $display("readback off done");
    // Key word restores page select and power enable
    @(negedge clk);
    pulse_seen = 1'b0;
    host.xfer(24, {8'h00, 1'b0, 7'h00, KEY}, r1);
    chk({7'h00, pulse_seen, pwr}, {7'h00, 1'b1, 16'h0200});
    chk({8'h00, page}, 24'h000000);
    // Chip select pulse with no clock edges must not replay the key write
    pulse_seen = 1'b0;
    host.xfer(0, 32'h00000000, r1);
    chk({23'h000000, pulse_seen}, 24'h000000);
    $display("soft reset done");
    // Second reset in mid-run
    pwr_dirty();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({pwr, page[7:0]}, {16'h0200, 8'h00});
    host.rd(7'h08, r1, r2);
    chk(r2, {1'b1, gs[6:0], 16'h0200});
    $display("second reset done");
    conclude();
  end
  // Leave non-reset values behind so the reset has work to do
  task automatic pwr_dirty;
    logic [23:0] d;
    host.xfer(24, {8'h00, 1'b0, 7'h08, 16'h0081}, d);
    host.xfer(24, {8'h00, 1'b0, 7'h01, 16'h0005}, d);
    chk({pwr, page[7:0]}, {16'h0081, 8'h05});
  endtask
endmodule // spb_spi_global_regs_tb
`default_nettype wire
